// file: common/scd_cfg.svh
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
// ********************************
// Register byte offsets
// ********************************
`define SCD_OFF_SYSCTL 8'h00
`define SCD_OFF_PAGEBASE 8'h04
`define SCD_OFF_EXTCTL 8'h08
`define SCD_OFF_DBGSTAT 8'h0C
`define SCD_OFF_DBGCTL 8'h10
`define SCD_OFF_RSVDA 8'h14
`define SCD_OFF_RSVDB 8'h18
// ********************************
// Field positions
// ********************************
`define SCD_B_V86 0
`define SCD_B_PMV 1
`define SCD_B_TSR 2
`define SCD_B_DBX 3
`define SCD_B_PSZ 4
`define SCD_B_PAX 5
`define SCD_B_MCK 6
`define SCD_B_GLB 7
`define SCD_B_CTR 8
`define SCD_B_FXS 9
`define SCD_B_XMM 10
`define SCD_B_NUM 5
`define SCD_B_WP 16
`define SCD_B_ALM 18
`define SCD_B_NWT 29
`define SCD_B_CDS 30
`define SCD_B_PG 31
`define SCD_B_XWT 3
`define SCD_B_XCD 4
`define SCD_B_BPT0 16
// ********************************
// Write masks, reset values and invalid access-rights bytes
// ********************************
`define SCD_MASK_SYSCTL 32'hE005003F
`define SCD_MASK_PAGEBASE 32'hFFFFFFFF
`define SCD_MASK_EXTCTL 32'h000007FF
`define SCD_MASK_DBGSTAT 32'h0000E00F
`define SCD_MASK_DBGCTL 32'hFFFF23FF
`define SCD_RST_SYSCTL 32'h00000000
`define SCD_RST_PAGEBASE 32'h00000000
`define SCD_RST_EXTCTL 32'h00000000
`define SCD_RST_DBGSTAT 32'h00000000
`define SCD_RST_DBGCTL 32'h00000000
`define SCD_AR_BAD_A 8'h80
`define SCD_AR_BAD_B 8'h00
`endif

// file: common/scd_pkg.sv
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_BP_EXEC = 2'b00,
        SCD_BP_WRITE = 2'b01,
        SCD_BP_IO = 2'b10,
        SCD_BP_RDWR = 2'b11
    } scd_bp_e;
    typedef logic [31:0] scd_word_t;
endpackage

// file: dv/tb_system_control_debug_regs.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"
module tb_system_control_debug_regs
    import scd_pkg::*;
;
    typedef struct {logic [7:0] a; scd_word_t w; scd_word_t r;
        logic e;} scd_rrow_s;
    typedef struct {scd_word_t s; scd_word_t x; logic [1:0] c;
        logic [11:0] f;} scd_crow_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, w_err;
    logic [7:0] paddr, ar_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, bp_hit, bp_defined;
    logic [1:0] cpl;
    logic task_switch, hw_error, fp_error, sup_write, page_read_only;
    logic alignment_check_flag, nonpaged_cycle, seg_load, seg_accessed;
    logic simd_exception_os_support, extended_state_save_support, pa_wide;
    logic tlb_flush, tlb_keep_global, ctr_read_ok, tsc_read_ok, v86_vif_en;
    logic pm_vif_en;
    logic page4m_en, page2m_en, machine_check, fp_err_report, wp_fault;
    logic align_check_en, wt_inval_en, cache_en, ext_cache_disable_pin;
    logic ext_write_through_pin, desc_invalid, seg_lock_rmw;
    logic invalid_opcode_exception;
    logic [11:0] flags;
    scd_bp_e [3:0] bp_kind;
    int fails, comparisons, c;
    scd_rrow_s rtab[8] = '{
        '{`SCD_OFF_SYSCTL, 32'hFFFFFFFF, 32'hE005003F, 1'b0},
        '{`SCD_OFF_PAGEBASE, 32'hA5A5A5A5, 32'hA5A5A5A5, 1'b0},
        '{`SCD_OFF_EXTCTL, 32'hFFFFF7F7, 32'h000007F7, 1'b0},
        '{`SCD_OFF_DBGSTAT, 32'hFFFFFFFF, 32'h0000E00F, 1'b0},
        '{`SCD_OFF_DBGCTL, 32'hFFFFFFFF, 32'hFFFF23FF, 1'b0},
        '{`SCD_OFF_RSVDA, 32'h00001000, 32'h00000000, 1'b0},
        '{`SCD_OFF_RSVDB, 32'h00005800, 32'h00000000, 1'b0},
        '{8'h1C, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
    // Flags: simd fxs pa keepg pmc tsc v86 pmv 4m 2m wt cache
    scd_crow_s ctab[5] = '{
        '{32'h00000000, 32'h00000000, 2'd3, 12'h043},
        '{32'h00000000, 32'h000007F7, 2'd3, 12'hDB7},
        '{32'hE0000000, 32'h00000030, 2'd0, 12'h2C4},
        '{32'h00000000, 32'h00000014, 2'd0, 12'h0CB},
        '{32'h00000000, 32'h00000004, 2'd1, 12'h003}};
    logic [7:0] ar_tab[4] = '{8'h80, 8'h00, 8'h81, 8'h7F};
    assign flags = {simd_exception_os_support, extended_state_save_support,
        pa_wide, tlb_keep_global, ctr_read_ok, tsc_read_ok, v86_vif_en,
        pm_vif_en, page4m_en, page2m_en, wt_inval_en, cache_en};

    scd_regs u_scd_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cpl, .task_switch,
        .hw_error, .fp_error, .sup_write, .page_read_only,
        .alignment_check_flag, .nonpaged_cycle, .seg_load, .seg_accessed,
        .ar_byte, .bp_hit, .simd_exception_os_support,
        .extended_state_save_support, .pa_wide, .tlb_flush, .tlb_keep_global,
        .ctr_read_ok, .tsc_read_ok, .v86_vif_en, .pm_vif_en, .page4m_en,
        .page2m_en, .machine_check, .fp_err_report, .wp_fault, .align_check_en,
        .wt_inval_en, .cache_en, .ext_cache_disable_pin,
        .ext_write_through_pin, .desc_invalid, .seg_lock_rmw, .bp_kind,
        .bp_defined, .invalid_opcode_exception);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(string what, logic exp, logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    // Holds the request until pready is sampled high, no fixed latency
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts one-cycle pulses over three samples after the cause
    task automatic count_pulse(logic which, output int n);
        n = 0;
        repeat (3) begin
            #1;
            if ((which ? invalid_opcode_exception : tlb_flush) === 1'b1) n++;
            @(posedge pclk);
        end
    endtask
    task automatic ev(logic exp);
        @(posedge pclk);
        hw_error <= 1'b1;
        fp_error <= 1'b1;
        @(posedge pclk);
        hw_error <= 1'b0;
        fp_error <= 1'b0;
        #1;
        chk_bit("machine_check", exp, machine_check);
        chk_bit("fp_err_report", exp, fp_err_report);
        tick(1);
        chk_bit("machine_check end", 1'b0, machine_check);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cpl, task_switch} = '0;
        {hw_error, fp_error, sup_write, page_read_only, ar_byte, bp_hit} = '0;
        {alignment_check_flag, nonpaged_cycle, seg_load, seg_accessed} = '0;
        pstrb = 4'hF;
        fails = 0;
        comparisons = 0;
        repeat (15) @(posedge pclk);
        #1;
        chk_word("bp_defined in reset", 32'hF, {28'h0, bp_defined});
        chk_bit("pready", 1'b1, pready);
        @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_word("reset value", 32'h0, rd);
        end
        $display("test reset done");
        foreach (rtab[i]) begin
            apb(1'b1, rtab[i].a, rtab[i].w);
            w_err = err;
            apb(1'b0, rtab[i].a, 32'h0);
            chk_word("readback", rtab[i].r, rd);
            chk_bit("write err", rtab[i].e, w_err);
            chk_bit("read err", rtab[i].e, err);
        end
        $display("test register table done");
        foreach (ctab[i]) begin
            @(posedge pclk);
            cpl <= ctab[i].c;
            apb(1'b1, `SCD_OFF_SYSCTL, ctab[i].s);
            apb(1'b1, `SCD_OFF_EXTCTL, ctab[i].x);
            tick(2);
            chk_word("flags", {20'h0, ctab[i].f},
                {20'h0, flags});
        end
        $display("test control flags done");
        apb(1'b1, `SCD_OFF_EXTCTL, 32'h00000040);
        apb(1'b1, `SCD_OFF_SYSCTL, 32'h00050020);
        ev(1'b1);
        apb(1'b1, `SCD_OFF_EXTCTL, 32'h00000000);
        apb(1'b1, `SCD_OFF_SYSCTL, 32'h00050000);
        ev(1'b0);
        @(posedge pclk);
        sup_write <= 1'b1;
        page_read_only <= 1'b1;
        alignment_check_flag <= 1'b1;
        tick(2);
        chk_bit("wp_fault", 1'b1, wp_fault);
        chk_bit("align_check_en", 1'b1, align_check_en);
        @(posedge pclk);
        page_read_only <= 1'b0;
        alignment_check_flag <= 1'b0;
        tick(2);
        chk_bit("wp_fault off", 1'b0, wp_fault);
        chk_bit("align off", 1'b0, align_check_en);
        $display("test events done");
        apb(1'b1, `SCD_OFF_SYSCTL, 32'h80000000);
        apb(1'b1, `SCD_OFF_PAGEBASE, 32'h00000010);
        count_pulse(1'b0, c);
        chk_word("flush on page base write", 1, c);
        nonpaged_cycle <= 1'b1;
        tick(2);
        chk_word("pins", 32'h2,
            {30'h0, ext_cache_disable_pin, ext_write_through_pin});
        apb(1'b1, `SCD_OFF_PAGEBASE, 32'h00000008);
        tick(2);
        chk_word("pins", 32'h1,
            {30'h0, ext_cache_disable_pin, ext_write_through_pin});
        @(posedge pclk);
        nonpaged_cycle <= 1'b0;
        task_switch <= 1'b1;
        @(posedge pclk);
        task_switch <= 1'b0;
        count_pulse(1'b0, c);
        chk_word("flush on task switch", 1, c);
        chk_word("pins idle", 32'h0,
            {30'h0, ext_cache_disable_pin, ext_write_through_pin});
        $display("test paging done");
        foreach (ar_tab[i]) begin
            @(posedge pclk);
            ar_byte <= ar_tab[i];
            tick(1);
            chk_bit("desc_invalid", ar_tab[i] == 8'h80 || ar_tab[i] == 8'h00,
                desc_invalid);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {seg_load, seg_accessed} <= 2'(i);
            tick(1);
            chk_bit("seg_lock_rmw", i == 2, seg_lock_rmw);
        end
        $display("test descriptors done");
        apb(1'b1, `SCD_OFF_EXTCTL, 32'h00000000);
        apb(1'b1, `SCD_OFF_DBGCTL, 32'h32100000);
        tick(3);
        chk_word("bp_kind", 32'hE4, {24'h0, bp_kind});
        chk_word("bp_defined", 32'hB, {28'h0, bp_defined});
        apb(1'b1, `SCD_OFF_EXTCTL, 32'h00000008);
        tick(3);
        chk_word("bp_defined ext", 32'hF, {28'h0, bp_defined});
        apb(1'b1, `SCD_OFF_RSVDB, 32'h00000001);
        chk_bit("reserved write err", 1'b1, err);
        count_pulse(1'b1, c);
        chk_word("invalid opcode pulse", 1, c);
        apb(1'b0, `SCD_OFF_DBGCTL, 32'h0);
        chk_word("control kept", 32'h32100000, rd);
        @(posedge pclk);
        bp_hit <= 4'h5;
        @(posedge pclk);
        bp_hit <= 4'h0;
        apb(1'b0, `SCD_OFF_DBGSTAT, 32'h0);
        chk_word("status hits", 32'h5, rd);
        $display("test debug done");
        apb(1'b1, `SCD_OFF_EXTCTL, 32'h000007FF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SCD_OFF_EXTCTL, 32'h0);
        chk_word("ext after reset", 32'h0, rd);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

// file: src/scd_bp_decode.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"
module scd_bp_decode
    import scd_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic [1:0] type_code, // Breakpoint type field
    input wire logic debug_ext, // Debug extensions enable
    output scd_bp_e kind_q, // Decoded access kind
    output logic defined_q // Low when the kind is undefined
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_q <= SCD_BP_EXEC;
            defined_q <= 1'b1;
        end else begin
            case (type_code)
                2'b00: kind_q <= SCD_BP_EXEC; // R20
                2'b01: kind_q <= SCD_BP_WRITE; // R20
                2'b10: kind_q <= SCD_BP_IO; // R20
                default: kind_q <= SCD_BP_RDWR; // R20
            endcase
            // I/O breakpoints only exist with debug extensions on
            defined_q <= !(type_code == 2'b10 && !debug_ext); // R20
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    bp_io_undef_a: assert property ( // R20
        type_code == 2'b10 |=> kind_q == SCD_BP_IO
            && defined_q == $past(debug_ext))
        else $error("io breakpoint decode wrong");
endmodule

// file: src/scd_regs.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "scd_cfg.svh"
// Summary of operation
// R1: Extension control bit 10 is writable: OS handles unmasked SIMD faults.
// R2: Extension control bit 9 is writable: OS saves extended FP/SIMD state.
// R3: Bit 5 with paging on widens physical addresses beyond 32 bits.
// R4: Bit 7 keeps global translation entries on task switch or base write.
// R5: Bit 8 allows performance counter reads at every privilege level.
// R6: Hardware reset clears the whole extension control register.
// R7: Timestamp restrict bit limits timestamp reads to privilege level 0.
// R8: Separate bits enable virtual interrupt flags in v8086 and protected mode.
// R9: 4-MByte pages need bit 4 in 32-bit paging; extended paging has 2-MByte.
// R10: Machine-check exception is raised only while its enable bit is set.
// R11: Numeric error bit routes FP errors to the internal exception path.
// R12: Write protect bit blocks supervisor writes to read-only pages.
// R13: Alignment checks need both the alignment mask bit and the flag.
// R14: Not-write-through clear enables write-through and invalidation cycles.
// R15: Cache disable bit clear enables the cache, set disables it.
// R16: Non-paged cycles with paging on drive cache pins from page base bits.
// R17: Descriptor access-rights bytes 80H and 00H are invalid.
// R18: Accessed-bit locked update happens only when the bit is clear.
// R19: Debug status bit 12 ignores writes and always reads zero.
// R20: Breakpoint type decodes exec, write, I/O (needs extensions), rd/wr.
// R21: Debug control bits 11, 12, 14 and 15 always read zero.
// R22: Reserved debug regs alias status/control, or invalid opcode if enabled.
module scd_regs
    import scd_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte lanes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [1:0] cpl, // Current privilege level
    input wire logic task_switch, // Task switch pulse
    input wire logic hw_error, // Hardware error event
    input wire logic fp_error, // Numeric error event
    input wire logic sup_write, // Supervisor write access
    input wire logic page_read_only, // Target page is read-only
    input wire logic alignment_check_flag, // Flag from the core
    input wire logic nonpaged_cycle, // Bus cycle without paging
    input wire logic seg_load, // Segment descriptor load
    input wire logic seg_accessed, // Accessed bit of descriptor
    input wire logic [7:0] ar_byte, // Descriptor access rights
    input wire logic [3:0] bp_hit, // Breakpoint hits
    output logic simd_exception_os_support, // OS SIMD fault support
    output logic extended_state_save_support, // OS saves ext state
    output logic pa_wide, // Physical address above 32 bits
    output logic tlb_flush, // Translation flush pulse
    output logic tlb_keep_global, // Flush spares global entries
    output logic ctr_read_ok, // Counter read allowed
    output logic tsc_read_ok, // Timestamp read allowed
    output logic v86_vif_en, // Virtual IF in v8086 mode
    output logic pm_vif_en, // Virtual IF in protected mode
    output logic page4m_en, // 4-MByte pages usable
    output logic page2m_en, // 2-MByte pages usable
    output logic machine_check, // Machine-check exception pulse
    output logic fp_err_report, // Internal numeric error pulse
    output logic wp_fault, // Supervisor write blocked
    output logic align_check_en, // Alignment checking active
    output logic wt_inval_en, // Write-through and invalidation on
    output logic cache_en, // Internal cache on
    output logic ext_cache_disable_pin, // External cache disable
    output logic ext_write_through_pin, // External write-through
    output logic desc_invalid, // Access rights value invalid
    output logic seg_lock_rmw, // Locked accessed-bit update
    output scd_bp_e [3:0] bp_kind, // Per breakpoint kind
    output logic [3:0] bp_defined, // Per breakpoint defined
    output logic invalid_opcode_exception // Invalid opcode pulse
);
    // ********************************
    // Bus decode
    // ********************************
    scd_word_t sysctl_q, pagebase_q, extctl_q, dbgstat_q, dbgctl_q;
    logic setup, access, wr_en, hit, rsvd_ref, trap_ref;
    logic [31:0] rd_d;
    logic [7:0] eff_addr;
    logic dbg_ext;

    assign dbg_ext = extctl_q[`SCD_B_DBX];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign rsvd_ref = paddr == `SCD_OFF_RSVDA || paddr == `SCD_OFF_RSVDB;
    assign trap_ref = rsvd_ref && dbg_ext; // R22
    // Reserved debug addresses fold onto status and control
    always_comb begin
        eff_addr = paddr;
        if (paddr == `SCD_OFF_RSVDA) begin
            eff_addr = `SCD_OFF_DBGSTAT; // R22
        end else if (paddr == `SCD_OFF_RSVDB) begin
            eff_addr = `SCD_OFF_DBGCTL; // R22
        end
    end

    always_comb begin
        hit = 1'b1;
        case (eff_addr)
            `SCD_OFF_SYSCTL: rd_d = sysctl_q;
            `SCD_OFF_PAGEBASE: rd_d = pagebase_q;
            `SCD_OFF_EXTCTL: rd_d = extctl_q;
            `SCD_OFF_DBGSTAT: rd_d = dbgstat_q;
            `SCD_OFF_DBGCTL: rd_d = dbgctl_q;
            default: begin
                rd_d = 32'h00000000;
                hit = 1'b0;
            end
        endcase
        if (trap_ref) begin
            rd_d = 32'h00000000;
            hit = 1'b0;
        end
    end

    // Zero-wait access: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign wr_en = access && pwrite && hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
            pslverr <= !hit;
        end
    end

    function automatic scd_word_t merge(input scd_word_t old,
                                        input scd_word_t wd,
                                        input logic [3:0] st,
                                        input scd_word_t mask);
        scd_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysctl_q <= `SCD_RST_SYSCTL;
        end else if (wr_en && eff_addr == `SCD_OFF_SYSCTL) begin
            sysctl_q <= merge(sysctl_q, pwdata, pstrb, `SCD_MASK_SYSCTL);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pagebase_q <= `SCD_RST_PAGEBASE;
        end else if (wr_en && eff_addr == `SCD_OFF_PAGEBASE) begin
            pagebase_q <= merge(pagebase_q, pwdata, pstrb,
                                `SCD_MASK_PAGEBASE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extctl_q <= `SCD_RST_EXTCTL; // R6
        end else if (wr_en && eff_addr == `SCD_OFF_EXTCTL) begin
            // Bits 9 and 10 are plain writable OS capability flags
            extctl_q <= merge(extctl_q, pwdata, pstrb,
                              `SCD_MASK_EXTCTL); // R1 R2
        end
    end

    // Breakpoint hits win over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbgstat_q <= `SCD_RST_DBGSTAT;
        end else if (wr_en && eff_addr == `SCD_OFF_DBGSTAT) begin
            dbgstat_q <= merge(dbgstat_q, pwdata, pstrb,
                               `SCD_MASK_DBGSTAT) | {28'h0000000, bp_hit};
        end else begin
            dbgstat_q <= dbgstat_q | {28'h0000000, bp_hit}; // R19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbgctl_q <= `SCD_RST_DBGCTL;
        end else if (wr_en && eff_addr == `SCD_OFF_DBGCTL) begin
            dbgctl_q <= merge(dbgctl_q, pwdata, pstrb,
                              `SCD_MASK_DBGCTL); // R21
        end
    end

    // ********************************
    // Effects on the core
    // ********************************
    logic paging, pb_wr;
    assign paging = sysctl_q[`SCD_B_PG];
    assign pb_wr = wr_en && eff_addr == `SCD_OFF_PAGEBASE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            simd_exception_os_support <= 1'b0;
            extended_state_save_support <= 1'b0;
            pa_wide <= 1'b0;
            ctr_read_ok <= 1'b0;
            tsc_read_ok <= 1'b0;
            v86_vif_en <= 1'b0;
            pm_vif_en <= 1'b0;
            page4m_en <= 1'b0;
            page2m_en <= 1'b0;
        end else begin
            simd_exception_os_support <= extctl_q[`SCD_B_XMM]; // R1
            extended_state_save_support <= extctl_q[`SCD_B_FXS]; // R2
            pa_wide <= extctl_q[`SCD_B_PAX] && paging; // R3
            ctr_read_ok <= extctl_q[`SCD_B_CTR] || cpl == 2'b00; // R5
            tsc_read_ok <= !extctl_q[`SCD_B_TSR] || cpl == 2'b00; // R7
            v86_vif_en <= extctl_q[`SCD_B_V86]; // R8
            pm_vif_en <= extctl_q[`SCD_B_PMV]; // R8
            page4m_en <= extctl_q[`SCD_B_PSZ]
                && !extctl_q[`SCD_B_PAX]; // R9
            page2m_en <= extctl_q[`SCD_B_PAX]; // R9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tlb_flush <= 1'b0;
            tlb_keep_global <= 1'b0;
        end else begin
            tlb_flush <= task_switch || pb_wr;
            // Global entries survive only while the enable is set
            tlb_keep_global <= extctl_q[`SCD_B_GLB]; // R4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_check <= 1'b0;
            fp_err_report <= 1'b0;
            wp_fault <= 1'b0;
            align_check_en <= 1'b0;
            wt_inval_en <= 1'b0;
            cache_en <= 1'b0;
        end else begin
            machine_check <= hw_error && extctl_q[`SCD_B_MCK]; // R10
            fp_err_report <= fp_error && sysctl_q[`SCD_B_NUM]; // R11
            wp_fault <= sysctl_q[`SCD_B_WP] && sup_write
                && page_read_only; // R12
            align_check_en <= sysctl_q[`SCD_B_ALM]
                && alignment_check_flag; // R13
            wt_inval_en <= !sysctl_q[`SCD_B_NWT]; // R14
            cache_en <= !sysctl_q[`SCD_B_CDS]; // R15
        end
    end

    // Pins follow the page base only on non-paged cycles with paging on; low otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_cache_disable_pin <= 1'b0;
            ext_write_through_pin <= 1'b0;
        end else begin
            ext_cache_disable_pin <= paging && nonpaged_cycle
                && pagebase_q[`SCD_B_XCD]; // R16
            ext_write_through_pin <= paging && nonpaged_cycle
                && pagebase_q[`SCD_B_XWT]; // R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_invalid <= 1'b0;
            seg_lock_rmw <= 1'b0;
            invalid_opcode_exception <= 1'b0;
        end else begin
            desc_invalid <= ar_byte == `SCD_AR_BAD_A
                || ar_byte == `SCD_AR_BAD_B; // R17
            // Skipping the locked cycle saves bus traffic on reloads
            seg_lock_rmw <= seg_load && !seg_accessed; // R18
            invalid_opcode_exception <= access && trap_ref; // R22
        end
    end

    // ********************************
    // Breakpoint type decode
    // ********************************
    for (genvar g = 0; g < 4; g++) begin : g_bp
        scd_bp_decode u_dec (
            .pclk(pclk),
            .presetn(presetn),
            .type_code(dbgctl_q[`SCD_B_BPT0 + 4*g +: 2]), // R20
            .debug_ext(dbg_ext),
            .kind_q(bp_kind[g]),
            .defined_q(bp_defined[g])
        );
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ext_reset_a: assert property ( // R6
        $rose(presetn) |-> extctl_q == 32'h00000000)
        else $error("extension control not zero after reset");
    stat_bit12_a: assert property ( // R19
        wr_en && eff_addr == `SCD_OFF_DBGSTAT && pstrb[1] |=>
            !dbgstat_q[12])
        else $error("status bit 12 became set");
    ctl_rsvd_a: assert property ( // R21
        dbgctl_q[11] == 1'b0 && dbgctl_q[12] == 1'b0
            && dbgctl_q[15:14] == 2'b00)
        else $error("debug control reserved bit set");
    alias_ud_a: assert property ( // R22
        access && rsvd_ref && dbg_ext |-> pslverr ##1
            invalid_opcode_exception)
        else $error("reserved debug ref without invalid opcode");
    alias_read_a: assert property ( // R22
        setup && !pwrite && paddr == `SCD_OFF_RSVDA && !dbg_ext |=>
            prdata == $past(dbgstat_q) && !pslverr)
        else $error("alias read mismatch");
    pa_width_a: assert property ( // R3
        ##1 pa_wide == $past(extctl_q[`SCD_B_PAX] && paging))
        else $error("address width select wrong");
    tsc_priv_a: assert property ( // R7
        extctl_q[`SCD_B_TSR] && cpl != 2'b00 |=> !tsc_read_ok)
        else $error("timestamp read allowed above level 0");
    mc_gate_a: assert property ( // R10
        hw_error && !extctl_q[`SCD_B_MCK] |=> !machine_check)
        else $error("machine check not suppressed");
    pin_drive_a: assert property ( // R16
        paging && nonpaged_cycle |=> ext_cache_disable_pin
            == $past(pagebase_q[`SCD_B_XCD]))
        else $error("cache disable pin wrong");
    cache_en_a: assert property ( // R15
        sysctl_q[`SCD_B_CDS] ##1 sysctl_q[`SCD_B_CDS] |-> !cache_en)
        else $error("cache on while disabled");
    rmw_skip_a: assert property ( // R18
        seg_load && seg_accessed |=> !seg_lock_rmw)
        else $error("locked update on accessed descriptor");
    global_keep_a: assert property ( // R4
        pb_wr |=> tlb_flush && tlb_keep_global
            == $past(extctl_q[`SCD_B_GLB]))
        else $error("flush global handling wrong");

    alias_cov_c: cover property (access && rsvd_ref && !dbg_ext);
    trap_cov_c: cover property (invalid_opcode_exception);
    mc_cov_c: cover property (machine_check);
    flush_cov_c: cover property (tlb_flush && tlb_keep_global);
endmodule
